// ---- inc/ccg_pkg.sv ----
// ****************************************
// Shared constants for the current gain path
// ****************************************
package ccg_pkg;
  // Word widths
  localparam int unsigned ADC_W = 24;
  localparam int unsigned DSP_W = 28;
  localparam int unsigned PORT_W = 32;
  localparam int unsigned IDX_W = 3;
  // Register indices on the host port
  localparam logic [2:0] IDX_INPUT_GAIN_SELECT = 3'h0;
  localparam logic [2:0] IDX_PHASE_A_CURRENT_GAIN = 3'h1;
  localparam logic [2:0] IDX_PHASE_B_CURRENT_GAIN = 3'h2;
  localparam logic [2:0] IDX_PHASE_C_CURRENT_GAIN = 3'h3;
  localparam logic [2:0] IDX_WAVE_A = 3'h4;
  localparam logic [2:0] IDX_WAVE_B = 3'h5;
  localparam logic [2:0] IDX_WAVE_C = 3'h6;
  // Field positions of input_gain_select
  localparam int unsigned CUR_SEL_LSB = 0;
  localparam int unsigned VOLT_SEL_LSB = 6;
  localparam int unsigned SEL_W = 3;
  localparam logic [2:0] SEL_MAX = 3'h4;
  // Reset values
  localparam logic [15:0] INPUT_GAIN_SELECT_RST = 16'h0000;
  localparam logic [23:0] CURRENT_GAIN_RST = 24'h000000;
  // Converter code range and nominal full scale
  localparam logic [23:0] CODE_MIN = 24'h800000;
  localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [23:0] FULL_SCALE_POS = 24'h5A7540;
  localparam logic [23:0] FULL_SCALE_NEG = 24'hA58AC0;
  // Unity gain weight, two to the 23rd
  localparam int unsigned GAIN_FRAC = 23;
  // Modulator and output rates
  localparam int unsigned MOD_DIV = 16;
  localparam real MOD_RATE_MHZ = 1.024;
  localparam real SAMPLE_RATE_KSPS = 8.0;
  localparam int unsigned DECIM = int'(MOD_RATE_MHZ * 1000.0 / SAMPLE_RATE_KSPS);
endpackage

// ---- hdl/ccg_fifo.sv ----
`timescale 1ns/10ps
// ****************************************
// Sample FIFO
// ****************************************
module ccg_fifo #(
  parameter int unsigned WIDTH = 84,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("ccg_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty straight from the level count
  assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage, no reset needed for data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule // ccg_fifo

// ---- hdl/ccg_gain_path.sv ----
`timescale 1ns/10ps
// Overview of operation
// [RQ1] Current amplifier gain 1,2,4,8,16 comes from bits 2..0 of the gain select register.
// [RQ2] Voltage amplifier gain 1,2,4,8,16 comes from bits 8..6 of the same register.
// [RQ3] All converters run in full-power mode and are powered down in sleep mode.
// [RQ4] The modulator clock is the master clock divided by 16, nominally 1.024 MHz.
// [RQ5] Each current converter delivers signed 24-bit words at 8 kSPS.
// [RQ6] Converter codes stay within 0x800000 to 0x7FFFFF.
// [RQ7] Full scale is 0x5A7540 / 0xA58AC0 and all channels treat equal codes identically.
// [RQ8] Each phase current is multiplied by one plus its signed gain over two to the 23rd.
// [RQ9] The host writes 0x400000 for +50 percent and 0xC00000 for -50 percent.
// [RQ10] The scaled current feeds the downstream stream and the stored waveform samples.
// [RQ11] Processing uses 28-bit values and register words travel as 32 bits.
// [RQ12] A gain register reads as 32 bits: top four zero, bits 27..24 copies of the sign.
// [RQ13] Each phase gain register resets to zero, giving unity gain.
module ccg_gain_path #(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned DECIM_CNT = ccg_pkg::DECIM
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Power mode pin
  input wire logic sleep_mode,
  // Converter control
  output logic adc_power_en,
  output logic mod_clk_en,
  output logic sample_tick,
  output logic [2:0] current_input_gain_select,
  output logic [2:0] voltage_input_gain_select,
  // Converter samples
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [23:0] smp_ia,
  input wire logic [23:0] smp_ib,
  input wire logic [23:0] smp_ic,
  // Scaled current stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [27:0] out_ia,
  output logic [27:0] out_ib,
  output logic [27:0] out_ic,
  // Host register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_idx,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid
);
  localparam int unsigned FW = 3 * ccg_pkg::DSP_W;

  if (FIFO_DEPTH < 2 || DECIM_CNT < 2) begin : g_chk
    $error("ccg_gain_path parameters out of range");
  end

  // ****************************************
  // Power mode pin
  // ****************************************
  logic sleep_s1_q;
  logic sleep_s2_q;
  logic full_pwr;

  // Two-stage synchroniser for the mode pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sleep_s1_q <= 1'b1;
      sleep_s2_q <= 1'b1;
    end else begin
      sleep_s1_q <= sleep_mode;
      sleep_s2_q <= sleep_s1_q;
    end
  end
  assign full_pwr = !sleep_s2_q;

  // Converter supply follows the mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adc_power_en <= 1'b0;
    end else begin
      adc_power_en <= full_pwr; // RQ3
    end
  end

  // ****************************************
  // Modulator and output rate dividers
  // ****************************************
  logic [3:0] mod_cnt_q;
  logic [$clog2(DECIM_CNT)-1:0] dec_cnt_q;

  // Divide by 16; held still in sleep to save toggling
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mod_cnt_q <= 4'h0;
      mod_clk_en <= 1'b0;
    end else if (!full_pwr) begin
      mod_cnt_q <= 4'h0;
      mod_clk_en <= 1'b0;
    end else begin
      mod_cnt_q <= mod_cnt_q + 4'h1;
      mod_clk_en <= (mod_cnt_q == 4'(ccg_pkg::MOD_DIV - 1)); // RQ4
    end
  end

  // Output word rate: one per DECIM modulator beats
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dec_cnt_q <= '0;
      sample_tick <= 1'b0;
    end else if (!full_pwr) begin
      dec_cnt_q <= '0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (mod_clk_en) begin
        if (dec_cnt_q == $bits(dec_cnt_q)'(DECIM_CNT - 1)) begin
          dec_cnt_q <= '0;
          sample_tick <= 1'b1; // RQ5
        end else begin
          dec_cnt_q <= dec_cnt_q + $bits(dec_cnt_q)'(1);
        end
      end
    end
  end

  // ****************************************
  // Host registers
  // ****************************************
  logic [15:0] gain_sel_q;
  logic [23:0] igain_q [3];
  logic [23:0] wave_q [3];

  // Amplifier gain select register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gain_sel_q <= ccg_pkg::INPUT_GAIN_SELECT_RST;
    end else if (reg_wr && reg_idx == ccg_pkg::IDX_INPUT_GAIN_SELECT) begin
      gain_sel_q <= reg_wdata[15:0];
    end
  end

  // Selects drive the amplifiers; codes above 16x clamp to 16x
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      current_input_gain_select <= 3'h0;
      voltage_input_gain_select <= 3'h0;
    end else begin
      current_input_gain_select <= (gain_sel_q[ccg_pkg::CUR_SEL_LSB +: ccg_pkg::SEL_W] > ccg_pkg::SEL_MAX) ?
        ccg_pkg::SEL_MAX : gain_sel_q[ccg_pkg::CUR_SEL_LSB +: ccg_pkg::SEL_W]; // RQ1
      voltage_input_gain_select <= (gain_sel_q[ccg_pkg::VOLT_SEL_LSB +: ccg_pkg::SEL_W] > ccg_pkg::SEL_MAX) ?
        ccg_pkg::SEL_MAX : gain_sel_q[ccg_pkg::VOLT_SEL_LSB +: ccg_pkg::SEL_W]; // RQ2
    end
  end

  // Phase gains, low 24 bits of the written word kept
  for (genvar p = 0; p < 3; p++) begin : g_gain
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        igain_q[p] <= ccg_pkg::CURRENT_GAIN_RST; // RQ13
      end else if (reg_wr && reg_idx == ccg_pkg::IDX_PHASE_A_CURRENT_GAIN + 3'(p)) begin
        igain_q[p] <= reg_wdata[23:0]; // RQ9
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_idx)
          ccg_pkg::IDX_INPUT_GAIN_SELECT: reg_rdata <= {16'h0000, gain_sel_q};
          ccg_pkg::IDX_PHASE_A_CURRENT_GAIN: reg_rdata <= {4'h0, {4{igain_q[0][23]}}, igain_q[0]}; // RQ12
          ccg_pkg::IDX_PHASE_B_CURRENT_GAIN: reg_rdata <= {4'h0, {4{igain_q[1][23]}}, igain_q[1]}; // RQ12
          ccg_pkg::IDX_PHASE_C_CURRENT_GAIN: reg_rdata <= {4'h0, {4{igain_q[2][23]}}, igain_q[2]}; // RQ12
          ccg_pkg::IDX_WAVE_A: reg_rdata <= {{8{wave_q[0][23]}}, wave_q[0]}; // RQ11
          ccg_pkg::IDX_WAVE_B: reg_rdata <= {{8{wave_q[1][23]}}, wave_q[1]}; // RQ11
          ccg_pkg::IDX_WAVE_C: reg_rdata <= {{8{wave_q[2][23]}}, wave_q[2]}; // RQ11
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // Sample capture and gain multiply
  // ****************************************
  logic s_vld_q;
  logic s_vld_d;
  logic [23:0] raw_q [3];
  logic [27:0] scaled [3];
  logic [23:0] sat [3];
  logic accept;
  logic push;
  logic f_in_ready;
  logic f_out_valid;
  logic [FW-1:0] f_out_data;
  logic pop;

  assign accept = smp_valid && smp_ready;
  assign push = s_vld_q && f_in_ready;
  assign s_vld_d = (s_vld_q && !push) || accept;

  // One sample held; registered ready means a free slot next cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_vld_q <= 1'b0;
      smp_ready <= 1'b0;
    end else begin
      s_vld_q <= s_vld_d;
      smp_ready <= full_pwr && !s_vld_d; // RQ3
    end
  end

  // Same arithmetic on every channel so equal codes under equal gains give equal results
  for (genvar p = 0; p < 3; p++) begin : g_ch
    logic signed [48:0] prod;
    logic signed [25:0] shifted;

    always_ff @(posedge sys_clk) begin
      if (accept) begin
        raw_q[p] <= (p == 0) ? smp_ia : (p == 1) ? smp_ib : smp_ic; // RQ7
      end
    end

    // x * (2^23 + g) / 2^23; arithmetic shift truncates toward minus
    assign prod = $signed(raw_q[p]) * $signed({1'b0, 1'b1, 23'h000000} + {{2{igain_q[p][23]}}, igain_q[p]}); // RQ8
    assign shifted = 26'(prod >>> ccg_pkg::GAIN_FRAC);
    assign scaled[p] = {{2{shifted[25]}}, shifted}; // RQ11

    // Waveform words are 24-bit; clip the doubled range to the code limits
    assign sat[p] = (shifted > 26'sh07FFFFF) ? ccg_pkg::CODE_MAX :
                    (shifted < -26'sh0800000) ? ccg_pkg::CODE_MIN : shifted[23:0]; // RQ6

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        wave_q[p] <= 24'h000000;
      end else if (push) begin
        wave_q[p] <= sat[p]; // RQ10
      end
    end
  end

  // ****************************************
  // Buffered stream to the downstream calculations
  // ****************************************
  ccg_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(s_vld_q),
    .in_ready(f_in_ready),
    .in_data({scaled[2], scaled[1], scaled[0]}), // RQ10
    .out_valid(f_out_valid),
    .out_ready(pop),
    .out_data(f_out_data)
  );

  assign pop = f_out_valid && (!out_valid || out_ready);

  // Output register stage; a stalled consumer backs up into the FIFO
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_ia <= 28'h0000000;
      out_ib <= 28'h0000000;
      out_ic <= 28'h0000000;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_ia <= f_out_data[27:0];
      out_ib <= f_out_data[55:28];
      out_ic <= f_out_data[83:56];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_cur_sel_clamp: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    1'b1 |=> current_input_gain_select ==
      (($past(gain_sel_q[2:0]) > ccg_pkg::SEL_MAX) ? ccg_pkg::SEL_MAX : $past(gain_sel_q[2:0])))
    else $error("current gain select mismatch");

  chk_volt_sel_track: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    reg_wr && reg_idx == ccg_pkg::IDX_INPUT_GAIN_SELECT && reg_wdata[8:6] <= ccg_pkg::SEL_MAX
    |=> ##1 voltage_input_gain_select == $past(reg_wdata[8:6], 2))
    else $error("voltage gain select mismatch");

  chk_sleep_power: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    sleep_mode [*3] |=> !adc_power_en && !smp_ready && !mod_clk_en)
    else $error("converters active in sleep");

  // Helper: clocks since the last modulator beat; a long repetition would slow the tools
  logic [4:0] mod_gap_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mod_gap_q <= 5'h00;
    end else if (mod_clk_en || !full_pwr) begin
      mod_gap_q <= 5'h00;
    end else if (mod_gap_q != 5'h1F) begin
      mod_gap_q <= mod_gap_q + 5'h01;
    end
  end

  // First beat after wake comes one clock later than the steady spacing
  chk_mod_div_spacing: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
    mod_gap_q <= 5'(ccg_pkg::MOD_DIV) && (!mod_clk_en || mod_gap_q >= 5'(ccg_pkg::MOD_DIV - 1)))
    else $error("modulator enable spacing wrong");

  chk_wave_range: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    push && (scaled[0][27:23] != {5{scaled[0][23]}}) |=> wave_q[0] == (scaled[0][27] ? ccg_pkg::CODE_MIN : ccg_pkg::CODE_MAX))
    else $error("waveform not clipped");

  chk_unity_gain: assert property (@(posedge sys_clk) disable iff (rst) // RQ8
    s_vld_q && igain_q[1] == 24'h000000 |-> scaled[1] == {{4{raw_q[1][23]}}, raw_q[1]})
    else $error("unity gain changes the sample");

  chk_half_gain: assert property (@(posedge sys_clk) disable iff (rst) // RQ9
    s_vld_q && igain_q[1] == 24'hC00000 && raw_q[1] == ccg_pkg::FULL_SCALE_POS |-> scaled[1] == 28'h02D3AA0)
    else $error("half gain wrong at full scale");

  chk_channels_equal: assert property (@(posedge sys_clk) disable iff (rst) // RQ7
    s_vld_q && raw_q[0] == raw_q[2] && igain_q[0] == igain_q[2] |-> scaled[0] == scaled[2])
    else $error("channels disagree on equal codes");

  chk_gain_readback: assert property (@(posedge sys_clk) disable iff (rst) // RQ12
    reg_rd && reg_idx == ccg_pkg::IDX_PHASE_B_CURRENT_GAIN |=>
    reg_rvalid && reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}} && reg_rdata[23:0] == igain_q[1])
    else $error("gain readback malformed");

  chk_stream_hold: assert property (@(posedge sys_clk) disable iff (rst) // RQ10
    out_valid && !out_ready |=> out_valid && $stable(out_ia) && $stable(out_ib) && $stable(out_ic))
    else $error("stream word dropped under stall");

  chk_tick_on_beat: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    sample_tick |-> $past(mod_clk_en) && $past(full_pwr))
    else $error("word tick off the modulator beat");

  // The product never needs more than 26 bits, so the top two always repeat the sign
  chk_stream_sign: assert property (@(posedge sys_clk) disable iff (rst) // RQ11
    out_valid |-> out_ia[27:26] == {2{out_ia[25]}} && out_ib[27:26] == {2{out_ib[25]}} &&
      out_ic[27:26] == {2{out_ic[25]}})
    else $error("stream word not sign extended");
endmodule // ccg_gain_path

// ---- dv/ccg_adc_model.sv ----
`timescale 1ns/10ps
// ****************************************
// Converter output model
// ****************************************
module ccg_adc_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sample handshake
  output logic smp_valid,
  input wire logic smp_ready,
  output logic [23:0] smp_ia,
  output logic [23:0] smp_ib,
  output logic [23:0] smp_ic
);
  // Idle until the bench asks for a word
  initial begin
    smp_valid = 1'b0;
    smp_ia = 24'h000000;
    smp_ib = 24'h000000;
    smp_ic = 24'h000000;
  end

  // Offer one word; a small limit models a refused offer
  task automatic send(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c, input int lim,
                      output bit taken);
    int n;
    n = 0;
    taken = 1'b0;
    @(posedge sys_clk);
    #2;
    smp_valid = 1'b1;
    smp_ia = a;
    smp_ib = b;
    smp_ic = c;
    while (!taken && n < lim) begin
      @(posedge sys_clk);
      taken = (smp_ready === 1'b1);
      n++;
    end
    #2;
    smp_valid = 1'b0;
    // Released lines never repeat the old word
    smp_ia = ~smp_ia;
    smp_ib = ~smp_ib;
    smp_ic = ~smp_ic;
  endtask
endmodule // ccg_adc_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  localparam int DEC = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sleep_mode = 1'b0;
  logic out_ready = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_idx = 3'h0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic adc_power_en, mod_clk_en, sample_tick, smp_valid, smp_ready, out_valid, reg_rvalid;
  logic [2:0] cur_sel, volt_sel;
  logic [23:0] smp_ia, smp_ib, smp_ic;
  logic [27:0] out_ia, out_ib, out_ic;
  logic [31:0] reg_rdata, rd;
  logic [23:0] gn [3] = '{24'h000000, 24'h000000, 24'h000000};
  logic [23:0] codes [4] = '{ccg_pkg::FULL_SCALE_POS, ccg_pkg::FULL_SCALE_NEG, ccg_pkg::CODE_MAX, ccg_pkg::CODE_MIN};
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  bit tk;

  ccg_gain_path #(.FIFO_DEPTH(8), .DECIM_CNT(DEC)) dut (.sys_clk(sys_clk), .rst(rst), .sleep_mode(sleep_mode),
    .adc_power_en(adc_power_en), .mod_clk_en(mod_clk_en), .sample_tick(sample_tick),
    .current_input_gain_select(cur_sel), .voltage_input_gain_select(volt_sel), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_ia(smp_ia), .smp_ib(smp_ib), .smp_ic(smp_ic), .out_valid(out_valid),
    .out_ready(out_ready), .out_ia(out_ia), .out_ib(out_ib), .out_ic(out_ic), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  ccg_adc_model adc (.sys_clk(sys_clk), .rst(rst), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_ia(smp_ia), .smp_ib(smp_ib), .smp_ic(smp_ic));

  // 50 ns period
  always #25 sys_clk = ~sys_clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(logic [2:0] idx, logic [31:0] d);
    @(posedge sys_clk);
    #2;
    reg_wr = 1'b1;
    reg_idx = idx;
    reg_wdata = d;
    @(posedge sys_clk);
    #2;
    reg_wr = 1'b0;
  endtask

  task automatic rd_reg(logic [2:0] idx, output logic [31:0] d);
    @(posedge sys_clk);
    #2;
    reg_rd = 1'b1;
    reg_idx = idx;
    @(posedge sys_clk);
    #2;
    reg_rd = 1'b0;
    check("read answer", {31'h0, reg_rvalid}, 32'h1);
    d = reg_rdata;
  endtask

  // Floor of x times one plus g over two to the 23rd
  function automatic logic [27:0] scale(logic [23:0] x, logic [23:0] g);
    longint p;
    p = longint'($signed(x)) * (64'sd8388608 + longint'($signed(g)));
    return 28'(p >>> 23);
  endfunction

  // Waveform word: clipped to the converter range, sign extended
  function automatic logic [31:0] clip(logic [27:0] s);
    longint v;
    v = longint'($signed(s));
    if (v > 8388607) return 32'h007FFFFF;
    if (v < -8388608) return 32'hFF800000;
    return 32'(v);
  endfunction

  task automatic take(logic [23:0] x);
    int w;
    w = 0;
    @(negedge sys_clk);
    while (out_valid !== 1'b1 && w < 60) begin
      @(negedge sys_clk);
      w++;
    end
    check("out_ia", {4'h0, out_ia}, {4'h0, scale(x, gn[0])});
    check("out_ib", {4'h0, out_ib}, {4'h0, scale(x, gn[1])});
    check("out_ic", {4'h0, out_ic}, {4'h0, scale(x, gn[2])});
    @(posedge sys_clk);
    #2;
  endtask

  // Clocks from one pulse to the next
  task automatic spacing(bit tick, output int gap);
    int t;
    t = 0;
    gap = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while ((tick ? sample_tick : mod_clk_en) !== 1'b1 && t < 300);
    do begin
      @(negedge sys_clk);
      gap++;
    end while ((tick ? sample_tick : mod_clk_en) !== 1'b1 && gap < 300);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    fork
      begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        summarize();
      end
    join_none
    repeat (20) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_reg(3'(i), rd);
      check("reset value", rd, 32'h00000000);
    end
    n = 0;
    while (adc_power_en !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    check("power on", {31'h0, adc_power_en}, 32'h1);
    // Every select code, out-of-range ones clamp to x16
    for (int c = 0; c < 8; c++) begin
      wr(3'h0, {23'h0, 3'(7 - c), 3'h0, 3'(c)});
      repeat (2) @(posedge sys_clk);
      #2;
      check("current select", {29'h0, cur_sel}, (c > 4) ? 32'h4 : 32'(c));
      check("voltage select", {29'h0, volt_sel}, (7 - c > 4) ? 32'h4 : 32'(7 - c));
    end
    // Gains still at reset: unity on every phase, equal codes give equal words
    out_ready = 1'b1;
    adc.send(ccg_pkg::FULL_SCALE_NEG, ccg_pkg::FULL_SCALE_NEG, ccg_pkg::FULL_SCALE_NEG, 20, tk);
    check("unity taken", {31'h0, tk}, 32'h1);
    take(ccg_pkg::FULL_SCALE_NEG);
    rd_reg(3'h5, rd);
    check("unity waveform", rd, {8'hFF, ccg_pkg::FULL_SCALE_NEG});
    gn = '{24'h400000, 24'hC00000, 24'h800000};
    wr(3'h1, 32'hFF400000);
    wr(3'h2, 32'h00C00000);
    wr(3'h3, 32'h00800000);
    for (int i = 0; i < 3; i++) begin
      rd_reg(3'(i + 1), rd);
      check("gain word", rd, {4'h0, {4{gn[i][23]}}, gn[i]});
    end
    out_ready = 1'b1;
    foreach (codes[k]) begin
      adc.send(codes[k], codes[k], codes[k], 20, tk);
      check("sample taken", {31'h0, tk}, 32'h1);
      take(codes[k]);
      for (int j = 0; j < 3; j++) begin
        rd_reg(3'(j + 4), rd);
        check("waveform", rd, clip(scale(codes[k], gn[j])));
      end
    end
    wr(3'h4, 32'h00000123);
    rd_reg(3'h4, rd);
    check("waveform kept", rd, clip(scale(codes[3], gn[0])));
    rd_reg(3'h7, rd);
    check("unused index", rd, 32'h00000000);
    // Stall the consumer, fill until refused, then drain in order
    out_ready = 1'b0;
    n = 0;
    tk = 1'b1;
    while (tk && n < 14) begin
      adc.send(24'(n + 1), 24'(n + 1), 24'(n + 1), 30, tk);
      if (tk) n++;
    end
    check("words buffered", {31'h0, n >= 8}, 32'h1);
    check("held back", {31'h0, smp_ready}, 32'h0);
    out_ready = 1'b1;
    for (int k = 0; k < n; k++) take(24'(k + 1));
    repeat (4) @(posedge sys_clk);
    #2;
    check("drained", {31'h0, out_valid}, 32'h0);
    spacing(1'b0, n);
    check("modulator spacing", 32'(n), 32'(ccg_pkg::MOD_DIV));
    spacing(1'b1, n);
    check("word spacing", 32'(n), 32'(ccg_pkg::MOD_DIV * DEC));
    // Sleep stops the converters and the modulator clock
    @(posedge sys_clk);
    #2;
    sleep_mode = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2;
    check("sleep power", {31'h0, adc_power_en}, 32'h0);
    check("sleep ready", {31'h0, smp_ready}, 32'h0);
    n = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (mod_clk_en === 1'b1) n++;
    end
    check("sleep modulator", 32'(n), 32'h0);
    @(posedge sys_clk);
    #2;
    sleep_mode = 1'b0;
    repeat (8) @(posedge sys_clk);
    #2;
    check("wake power", {31'h0, adc_power_en}, 32'h1);
    summarize();
  end
endmodule // testbench
